/* File: csr_core.v */
// What this block does
// - The core holds its own sixteen special registers for pins, counters, video, launch.
// - Unrestricted special registers work as destination or source like general registers.
// - Pin input, system counter and launch argument are source-only; writes ignored.
// - Phase registers readable as source; read-modify-write uses shadow, not live value.
// - Pin direction and output are whole 32-bit words; bit merges alter selected bits.
// - Pin input read returns all 32 pin states at once, read-only.
// - Second-port direction, input and output are reserved, with no pin function.
// - System counter reads as a 32-bit read-only register.
// - Return decodes from opcode 010111, immediate bit 1, condition 1111; other fields ignored.
// - Return takes four cycles; destination untouched unless result-store is set.
// - With result-store set and a general-register destination, return acts as call writing next address to low 9 bits.
// - Carry effect sets carry unless incremented address is zero; zero effect clears zero flag.
// - Address 1ff is the video scale register.
// - Return loads the program counter with the recorded return address.
`timescale 1ns/1ps
`include "csr_defs.vh"
module csr_core (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Instruction issue
  input wire instrValid,
  input wire [31:0] instrWord,
  output wire instrReady,
  output reg retDone,
  // Generic register write port (other instructions)
  input wire regWrEn,
  input wire [8:0] regWrAddr,
  input wire [31:0] regWrData,
  input wire regWrRmw,
  // Generic register read port, data one cycle later
  input wire [8:0] regRdAddr,
  input wire regRdIsDest,
  output reg [31:0] regRdData,
  // Pins and system inputs
  input wire [31:0] pinInputA,
  input wire [31:0] launchArgIn,
  input wire launchLoad,
  // Counter phase live values from the counter logic
  input wire [31:0] phaseALive,
  input wire [31:0] phaseBLive,
  // Register outputs
  output reg [31:0] pinDirectionA,
  output reg [31:0] pinOutputA,
  output reg [31:0] counterAControl,
  output reg [31:0] counterBControl,
  output reg [31:0] counterAFrequency,
  output reg [31:0] counterBFrequency,
  output reg [31:0] counterAPhaseWr,
  output reg [31:0] counterBPhaseWr,
  output reg phaseAWrStb,
  output reg phaseBWrStb,
  output reg [31:0] videoConfiguration,
  output reg [31:0] videoScale,
  output reg [31:0] systemCounter,
  // Core flags and program counter
  output reg [8:0] programCounter,
  output reg zeroFlag,
  output reg carryFlag
);
  localparam ST_IDLE = 2'b00;
  localparam ST_FETCH = 2'b01;
  localparam ST_EXEC = 2'b10;
  localparam ST_DONE = 2'b11;

  function isSpr;
    input [8:0] a;
    begin
      isSpr = (a >= `CSR_SPR_BASE);
    end
  endfunction

  function isReadOnly;
    input [8:0] a;
    begin
      isReadOnly = (a == `CSR_ADDR_INA) || (a == `CSR_ADDR_INB) ||
        (a == `CSR_ADDR_CNT) || (a == `CSR_ADDR_LAUNCH);
    end
  endfunction

  function isReserved;
    input [8:0] a;
    begin
      isReserved = (a == `CSR_ADDR_INB) || (a == `CSR_ADDR_PIN_OUTPUT_B) ||
        (a == `CSR_ADDR_PIN_DIRECTION_B);
    end
  endfunction

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] cyc_r;
  reg [31:0] instr_r;
  reg [31:0] launchArg_r;
  reg [31:0] phaseAShadow_r;
  reg [31:0] phaseBShadow_r;
  wire [31:0] pinInSync;
  wire [31:0] ramRdData;
  reg ramWrEn;
  reg [8:0] ramWrAddr;
  reg [31:0] ramWrData;
  reg [8:0] ramRdAddr;
  reg [8:0] rdAddr_r;
  reg rdIsDest_r;
  reg rdFromCore_r;
  wire isRet;
  wire [8:0] pcInc;
  wire [8:0] retDst;

  assign isRet = (instrWord[`CSR_OP_HI:`CSR_OP_LO] == `CSR_OP_RET) &&
    (instrWord[`CSR_IBIT] == `CSR_IBIT_RET) &&
    (instrWord[`CSR_CON_HI:`CSR_CON_LO] == `CSR_CON_ALWAYS);
  assign instrReady = (state_r == ST_IDLE);
  assign pcInc = programCounter + 9'h001;
  assign retDst = instr_r[`CSR_DST_HI:`CSR_DST_LO];

  // Filtered pins reach a read four clocks after they settle
  csr_sync uSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinAsync(pinInputA),
    .pinSync(pinInSync)
  );

  csr_ram uRam (
    .clk_sys(clk_sys),
    .wrEn(ramWrEn),
    .wrAddr(ramWrAddr),
    .wrData(ramWrData),
    .rdAddr(ramRdAddr),
    .rdData(ramRdData)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (instrValid && isRet) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: state_nxt = ST_EXEC;
      ST_EXEC: begin
        // The issue cycle is the first of the four, so one exec cycle is enough
        if (cyc_r == `CSR_RET_CYCLES - 3'h2) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // The return reads its destination so a call can keep bits 31:9
  // The address stays on it until the store, as the read data is registered
  always @* begin
    ramRdAddr = regRdAddr;
    if (state_r != ST_IDLE) begin
      ramRdAddr = retDst;
    end
    ramWrEn = 1'b0;
    ramWrAddr = regWrAddr;
    ramWrData = regWrData;
    if (state_r == ST_DONE && instr_r[`CSR_RBIT] && !isSpr(retDst)) begin
      ramWrEn = 1'b1;
      ramWrAddr = retDst;
      ramWrData = {ramRdData[31:9], programCounter};
    end else if (regWrEn && !isSpr(regWrAddr) && state_r == ST_IDLE) begin
      ramWrEn = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cyc_r <= 3'h0;
      instr_r <= `CSR_RST_WORD;
      retDone <= 1'b0;
      programCounter <= `CSR_RST_PC;
      zeroFlag <= 1'b0;
      carryFlag <= 1'b0;
    end else begin
      state_r <= state_nxt;
      retDone <= 1'b0;
      if (state_r == ST_IDLE) begin
        cyc_r <= 3'h1;
        if (instrValid && isRet) begin
          instr_r <= instrWord;
        end
      end else begin
        cyc_r <= cyc_r + 3'h1;
      end
      if (state_r == ST_FETCH) begin
        if (instr_r[`CSR_CBIT]) begin
          carryFlag <= (pcInc != 9'h000);
        end
        if (instr_r[`CSR_ZBIT]) begin
          zeroFlag <= 1'b0;
        end
        programCounter <= pcInc;
      end
      if (state_r == ST_DONE) begin
        retDone <= 1'b1;
        programCounter <= instr_r[`CSR_SRC_HI:`CSR_SRC_LO];
      end
    end
  end

  // Special register writes; a store from the return never lands here
  always @(posedge clk_sys) begin
    if (rst) begin
      pinDirectionA <= `CSR_RST_WORD;
      pinOutputA <= `CSR_RST_WORD;
      counterAControl <= `CSR_RST_WORD;
      counterBControl <= `CSR_RST_WORD;
      counterAFrequency <= `CSR_RST_WORD;
      counterBFrequency <= `CSR_RST_WORD;
      counterAPhaseWr <= `CSR_RST_WORD;
      counterBPhaseWr <= `CSR_RST_WORD;
      phaseAWrStb <= 1'b0;
      phaseBWrStb <= 1'b0;
      videoConfiguration <= `CSR_RST_WORD;
      videoScale <= `CSR_RST_WORD;
      systemCounter <= `CSR_RST_WORD;
      launchArg_r <= `CSR_RST_WORD;
      phaseAShadow_r <= `CSR_RST_WORD;
      phaseBShadow_r <= `CSR_RST_WORD;
    end else begin
      systemCounter <= systemCounter + 32'h00000001;
      phaseAWrStb <= 1'b0;
      phaseBWrStb <= 1'b0;
      if (launchLoad) begin
        launchArg_r <= launchArgIn;
      end
      if (ramWrEn == 1'b0 && regWrEn && isSpr(regWrAddr) && !isReadOnly(regWrAddr) &&
        !isReserved(regWrAddr)) begin
        case (regWrAddr)
          `CSR_ADDR_PIN_OUTPUT_A: pinOutputA <= regWrData;
          `CSR_ADDR_PIN_DIRECTION_A: pinDirectionA <= regWrData;
          `CSR_ADDR_COUNTER_A_CONTROL: counterAControl <= regWrData;
          `CSR_ADDR_COUNTER_B_CONTROL: counterBControl <= regWrData;
          `CSR_ADDR_COUNTER_A_FREQUENCY: counterAFrequency <= regWrData;
          `CSR_ADDR_COUNTER_B_FREQUENCY: counterBFrequency <= regWrData;
          `CSR_ADDR_COUNTER_A_PHASE: begin
            counterAPhaseWr <= regWrData;
            phaseAShadow_r <= regWrData;
            phaseAWrStb <= 1'b1;
          end
          `CSR_ADDR_COUNTER_B_PHASE: begin
            counterBPhaseWr <= regWrData;
            phaseBShadow_r <= regWrData;
            phaseBWrStb <= 1'b1;
          end
          `CSR_ADDR_VIDEO_CONFIGURATION: videoConfiguration <= regWrData;
          `CSR_ADDR_VIDEO_SCALE: videoScale <= regWrData;
          default: videoScale <= videoScale;
        endcase
      end
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      rdAddr_r <= `CSR_RST_PC;
      rdIsDest_r <= 1'b0;
      rdFromCore_r <= 1'b0;
    end else begin
      rdAddr_r <= regRdAddr;
      rdIsDest_r <= regRdIsDest;
      rdFromCore_r <= (state_r == ST_IDLE);
    end
  end

  // Read mux; a destination read of phase sees the shadow, not the live count
  always @* begin
    regRdData = ramRdData;
    if (isSpr(rdAddr_r)) begin
      case (rdAddr_r)
        `CSR_ADDR_LAUNCH: regRdData = launchArg_r;
        `CSR_ADDR_CNT: regRdData = systemCounter;
        `CSR_ADDR_INA: regRdData = pinInSync;
        `CSR_ADDR_PIN_OUTPUT_A: regRdData = pinOutputA;
        `CSR_ADDR_PIN_DIRECTION_A: regRdData = pinDirectionA;
        `CSR_ADDR_COUNTER_A_CONTROL: regRdData = counterAControl;
        `CSR_ADDR_COUNTER_B_CONTROL: regRdData = counterBControl;
        `CSR_ADDR_COUNTER_A_FREQUENCY: regRdData = counterAFrequency;
        `CSR_ADDR_COUNTER_B_FREQUENCY: regRdData = counterBFrequency;
        `CSR_ADDR_COUNTER_A_PHASE: regRdData = rdIsDest_r ? phaseAShadow_r : phaseALive;
        `CSR_ADDR_COUNTER_B_PHASE: regRdData = rdIsDest_r ? phaseBShadow_r : phaseBLive;
        `CSR_ADDR_VIDEO_CONFIGURATION: regRdData = videoConfiguration;
        `CSR_ADDR_VIDEO_SCALE: regRdData = videoScale;
        default: regRdData = `CSR_RST_WORD;
      endcase
    end
    if (isReserved(rdAddr_r)) begin
      regRdData = `CSR_RST_WORD;
    end
    // The RAM port serves a running return, so a RAM read issued then reads zero
    if (!rdFromCore_r && !isSpr(rdAddr_r)) begin
      regRdData = `CSR_RST_WORD;
    end
  end
endmodule

/* File: csr_core_assertions.sv */
`timescale 1ns/1ps
module csr_core_chk (
  // Clock and reset
  input logic clk_sys,
  input logic rst,
  // Instruction issue
  input logic instrValid,
  input logic [31:0] instrWord,
  input logic instrReady,
  input logic retDone,
  // Register access
  input logic regWrEn,
  input logic [8:0] regWrAddr,
  input logic [31:0] regWrData,
  input logic [8:0] regRdAddr,
  input logic [31:0] regRdData,
  // Observed state
  input logic [31:0] pinOutputA,
  input logic [31:0] counterAPhaseWr,
  input logic phaseAWrStb,
  input logic [31:0] systemCounter,
  input logic [8:0] programCounter,
  input logic zeroFlag,
  input logic carryFlag
);
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Dest and source fields are ignored by the decode
  wire take = instrValid && instrReady && instrWord[31:26] == 6'h17 && instrWord[22]
    && instrWord[21:18] == 4'hf;
  wire wrIdle = regWrEn && instrReady;

  property p_ret_done;
    take |=> !retDone [*3] ##1 retDone;
  endproperty
  a_ret_done: assert property (p_ret_done) else $error("return end pulse misplaced");
  property p_busy;
    take |=> !instrReady [*3] ##1 instrReady;
  endproperty
  a_busy: assert property (p_busy) else $error("issue ready wrong during return");
  property p_pc;
    take |-> ##4 programCounter == $past(instrWord[8:0], 4);
  endproperty
  a_pc: assert property (p_pc) else $error("program counter not loaded");
  // Incremented address wraps to zero only from the top word
  property p_carry;
    take && instrWord[24] |-> ##4 carryFlag == ($past(programCounter, 4) != 9'h1ff);
  endproperty
  a_carry: assert property (p_carry) else $error("carry result wrong");
  property p_zero;
    take && instrWord[25] |-> ##4 !zeroFlag;
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag not cleared");
  property p_cnt;
    !$past(rst) |-> systemCounter == $past(systemCounter) + 32'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("system counter disturbed");
  property p_pin_output_a;
    wrIdle && regWrAddr == 9'h1f4 |=> pinOutputA == $past(regWrData);
  endproperty
  a_pin_output_a: assert property (p_pin_output_a) else $error("pin output word not written");
  property p_phase;
    wrIdle && regWrAddr == 9'h1fc |=> phaseAWrStb && counterAPhaseWr == $past(regWrData);
  endproperty
  a_phase: assert property (p_phase) else $error("phase write not passed on");
  property p_rsvd;
    regRdAddr inside {9'h1f3, 9'h1f5, 9'h1f7} |=> regRdData == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved register not zero");

  c_store: cover property (take && instrWord[23]);
  c_wrap: cover property (take && programCounter == 9'h1ff);
  c_rsvd: cover property (regRdAddr == 9'h1f5);
endmodule

/* File: csr_core_bench.sv */
`timescale 1ns/1ps
module csr_core_bench;
  logic clk_sys = 0, rst = 1, instrValid = 0, regWrEn = 0, regWrRmw = 0;
  logic regRdIsDest = 0, launchLoad = 0;
  logic [31:0] instrWord = 0, regWrData = 0, pinInputA = 0, launchArgIn = 0;
  logic [31:0] phaseALive = 0, phaseBLive = 32'h0000_0bbb;
  logic [8:0] regWrAddr = 0, regRdAddr = 0;
  wire instrReady, retDone, phaseAWrStb, zeroFlag, carryFlag;
  wire [31:0] regRdData, pinOutputA, pinDirectionA, videoScale, counterAPhaseWr, systemCounter;
  wire [8:0] programCounter;
  logic [8:0] rw [8] = '{9'h1f4, 9'h1f6, 9'h1f8, 9'h1f9, 9'h1fa, 9'h1fb, 9'h1fe, 9'h1ff};
  int n_errors = 0, check_count = 0, cyc = 0;

  csr_core i_dut (.clk_sys, .rst, .instrValid, .instrWord, .instrReady, .retDone,
    .regWrEn, .regWrAddr, .regWrData, .regWrRmw, .regRdAddr, .regRdIsDest, .regRdData,
    .pinInputA, .launchArgIn, .launchLoad, .phaseALive, .phaseBLive, .pinDirectionA,
    .pinOutputA, .counterAControl(), .counterBControl(), .counterAFrequency(),
    .counterBFrequency(), .counterAPhaseWr, .counterBPhaseWr(), .phaseAWrStb,
    .phaseBWrStb(), .videoConfiguration(), .videoScale, .systemCounter, .programCounter,
    .zeroFlag, .carryFlag);

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  task final_report;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe dropped a full cycle before the next write starts
  task wr(input logic [8:0] a, input logic [31:0] d);
    regWrEn = 1;
    regWrAddr = a;
    regWrData = d;
    @(negedge clk_sys);
    regWrEn = 0;
    @(negedge clk_sys);
  endtask

  task rd(input logic [8:0] a, input logic dst, input logic [31:0] exp);
    regRdAddr = a;
    regRdIsDest = dst;
    @(negedge clk_sys);
    chk(regRdData, exp);
  endtask

  task ret(input logic [2:0] zcr, input logic [3:0] cn, input logic [8:0] d, s, input int lat);
    int i;
    instrWord = {6'h17, zcr, 1'b1, cn, d, s};
    instrValid = 1;
    @(negedge clk_sys);
    instrValid = 0;
    for (i = 1; i < 9 && retDone !== 1'b1; i++)
      @(negedge clk_sys);
    chk(i, lat);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 0;
    chk(pinOutputA, 32'h0);
    launchArgIn = 32'h1234_5678;
    launchLoad = 1;
    pinInputA = 32'ha5c3_0f96;
    @(negedge clk_sys);
    launchLoad = 0;
    wr(9'h1f0, 32'hffff_ffff);
    wr(9'h1f2, 32'h0);
    wr(9'h1f1, 32'h8000_0000);
    rd(9'h1f0, 0, 32'h1234_5678);
    rd(9'h1f2, 0, 32'ha5c3_0f96);
    rd(9'h1f1, 0, cyc - 19);
    for (int i = 0; i < 8; i++) begin
      wr(rw[i], {7'h0, rw[i], 16'hc0de});
      rd(rw[i], 0, {7'h0, rw[i], 16'hc0de});
    end
    chk(videoScale, 32'h01ff_c0de);
    chk(pinDirectionA, 32'h01f6_c0de);
    wr(9'h1f5, 32'hffff_ffff);
    wr(9'h1f7, 32'hffff_ffff);
    rd(9'h1f3, 0, 32'h0);
    rd(9'h1f5, 0, 32'h0);
    rd(9'h1f7, 1, 32'h0);
    // Live phase differs from what is written, so a mixup shows
    phaseALive = 32'h0bad_f00d;
    wr(9'h1fc, 32'h0000_5a5a);
    rd(9'h1fc, 1, 32'h0000_5a5a);
    rd(9'h1fc, 0, 32'h0bad_f00d);
    wr(9'h1fd, 32'h0000_a5a5);
    rd(9'h1fd, 1, 32'h0000_a5a5);
    rd(9'h1fd, 0, 32'h0000_0bbb);
    wr(9'h010, 32'habcd_e000);
    rd(9'h010, 0, 32'habcd_e000);
    ret(3'b111, 4'hf, 9'h010, 9'h123, 4);
    chk({23'h0, programCounter}, 32'h123);
    chk({30'h0, zeroFlag, carryFlag}, 32'h1);
    ret(3'b010, 4'hf, 9'h010, 9'h1ff, 4);
    rd(9'h010, 1, 32'habcd_e001);
    ret(3'b010, 4'hf, 9'h010, 9'h005, 4);
    chk({31'h0, carryFlag}, 32'h0);
    ret(3'b010, 4'h0, 9'h010, 9'h0aa, 9);
    chk({23'h0, programCounter}, 32'h005);
    final_report();
  end
endmodule

bind csr_core csr_core_chk i_chk (.clk_sys, .rst, .instrValid, .instrWord, .instrReady,
  .retDone, .regWrEn, .regWrAddr, .regWrData, .regRdAddr, .regRdData, .pinOutputA,
  .counterAPhaseWr, .phaseAWrStb, .systemCounter, .programCounter, .zeroFlag, .carryFlag);

/* File: csr_defs.vh */
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH
// Special register addresses in the 512-word register space
`define CSR_SPR_BASE 9'h1f0
`define CSR_ADDR_LAUNCH 9'h1f0
`define CSR_ADDR_CNT 9'h1f1
`define CSR_ADDR_INA 9'h1f2
`define CSR_ADDR_INB 9'h1f3
`define CSR_ADDR_PIN_OUTPUT_A 9'h1f4
`define CSR_ADDR_PIN_OUTPUT_B 9'h1f5
`define CSR_ADDR_PIN_DIRECTION_A 9'h1f6
`define CSR_ADDR_PIN_DIRECTION_B 9'h1f7
`define CSR_ADDR_COUNTER_A_CONTROL 9'h1f8
`define CSR_ADDR_COUNTER_B_CONTROL 9'h1f9
`define CSR_ADDR_COUNTER_A_FREQUENCY 9'h1fa
`define CSR_ADDR_COUNTER_B_FREQUENCY 9'h1fb
`define CSR_ADDR_COUNTER_A_PHASE 9'h1fc
`define CSR_ADDR_COUNTER_B_PHASE 9'h1fd
`define CSR_ADDR_VIDEO_CONFIGURATION 9'h1fe
`define CSR_ADDR_VIDEO_SCALE 9'h1ff
// Instruction fields
`define CSR_OP_HI 31
`define CSR_OP_LO 26
`define CSR_ZBIT 25
`define CSR_CBIT 24
`define CSR_RBIT 23
`define CSR_IBIT 22
`define CSR_CON_HI 21
`define CSR_CON_LO 18
`define CSR_DST_HI 17
`define CSR_DST_LO 9
`define CSR_SRC_HI 8
`define CSR_SRC_LO 0
`define CSR_OP_RET 6'h17
`define CSR_IBIT_RET 1'h1
`define CSR_CON_ALWAYS 4'hf
// Timing and reset values
`define CSR_RET_CYCLES 3'h4
`define CSR_RST_WORD 32'h00000000
`define CSR_RST_PC 9'h000
`endif

/* File: csr_ram.v */
`timescale 1ns/1ps
module csr_ram (
  // Clock
  input wire clk_sys,
  // Write port
  input wire wrEn,
  input wire [8:0] wrAddr,
  input wire [31:0] wrData,
  // Registered read port
  input wire [8:0] rdAddr,
  output reg [31:0] rdData
);
  reg [31:0] mem [0:511];
  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

/* File: csr_sync.v */
`timescale 1ns/1ps
`include "csr_defs.vh"
module csr_sync (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Asynchronous pins in, filtered level out
  input wire [31:0] pinAsync,
  output reg [31:0] pinSync
);
  reg [31:0] s1_r;
  reg [31:0] s2_r;
  reg [31:0] s3_r;
  genvar i;
  always @(posedge clk_sys) begin
    if (rst) begin
      s1_r <= `CSR_RST_WORD;
      s2_r <= `CSR_RST_WORD;
      s3_r <= `CSR_RST_WORD;
    end else begin
      s1_r <= pinAsync;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Each bit changes only once the second and third stages agree
  generate
    for (i = 0; i < 32; i = i + 1) begin : gBit
      always @(posedge clk_sys) begin
        if (rst) begin
          pinSync[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          pinSync[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule
